/* File: design/ofd_decoder.sv */
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ofd_decoder
   import ofd_pkg::*;
(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // decoded operand description
   output ofd_dec_s               dec
);
   logic              aw_held, next_aw_held;
   logic              w_held, next_w_held;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [DATA_W-1:0] w_data, next_w_data;
   logic [3:0]        w_strb, next_w_strb;
   logic              next_awready, next_wready;
   logic              next_bvalid, next_arready, next_rvalid;
   logic [1:0]        next_bresp, next_rresp;
   logic [DATA_W-1:0] next_rdata;
   logic              do_write;
   logic [31:0]       insn, next_insn;
   logic [15:0]       tail, next_tail;
   logic [31:0]       base, next_base;
   logic [31:0]       index, next_index;
   logic [15:0]       status, next_status;
   logic [8:0]        ctrl, next_ctrl;
   ofd_dec_s          next_dec;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // bus slave: address and data taken in either order
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_insn    = insn;
      next_tail    = tail;
      next_base    = base;
      next_index   = index;
      next_status  = status;
      next_ctrl    = ctrl;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = RESP_OKAY;
         unique case (aw_addr)
            OFS_INSN:   next_insn  = merge(insn, w_data, w_strb);
            OFS_TAIL:   next_tail  = 16'(merge({16'h0000, tail}, w_data,
                                               w_strb));
            OFS_BASE:   next_base  = merge(base, w_data, w_strb);
            OFS_INDEX:  next_index = merge(index, w_data, w_strb);
            // undefined status bits never store
            OFS_STATUS: next_status = 16'(merge({16'h0000, status},
                                         w_data, w_strb)) & STATUS_MASK;
            OFS_CTRL:   next_ctrl  = 9'(merge({23'h000000, ctrl},
                                         w_data, w_strb));
            OFS_DECODE, OFS_ADDR, OFS_IMM, OFS_SEL: ;
            default:    next_bresp = RESP_SLVERR;
         endcase
      end
      next_awready = !next_aw_held;
      next_wready  = !next_w_held;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         aw_held       <= 1'b0;
         aw_addr       <= '0;
         w_held        <= 1'b0;
         w_data        <= '0;
         w_strb        <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         insn          <= '0;
         tail          <= '0;
         base          <= '0;
         index         <= '0;
         status        <= '0;
         ctrl          <= '0;
      end else begin
         aw_held       <= next_aw_held;
         aw_addr       <= next_aw_addr;
         w_held        <= next_w_held;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         insn          <= next_insn;
         tail          <= next_tail;
         base          <= next_base;
         index         <= next_index;
         status        <= next_status;
         ctrl          <= next_ctrl;
      end
   end

   // read side: data registered on the same edge that takes the address
   always_comb begin
      next_arready = s_axi_arready;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid  = 1'b0;
         next_arready = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid  = 1'b1;
         next_rresp   = RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_INSN:   next_rdata = insn;
            OFS_TAIL:   next_rdata = {16'h0000, tail};
            OFS_BASE:   next_rdata = base;
            OFS_INDEX:  next_rdata = index;
            OFS_STATUS: next_rdata = {16'h0000, status};
            OFS_CTRL:   next_rdata = {23'h000000, ctrl};
            OFS_DECODE: next_rdata = {13'h0000, dec.shift_count,
                                      dec.cond_true, dec.rep_continue,
                                      dec.imm_len, dec.disp_len,
                                      dec.direct_addr, dec.reg_mode,
                                      dec.to_reg, dec.word_op, dec.valid};
            OFS_ADDR:   next_rdata = {dec.disp, dec.location};
            OFS_IMM:    next_rdata = {16'h0000, dec.imm};
            OFS_SEL:    next_rdata = {22'h000000, dec.seg, dec.rm_high,
                                      dec.rm_sel, dec.reg_high,
                                      dec.reg_sel};
            default: begin
               next_rdata = '0;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

   // decode of the held instruction bytes
   logic [7:0]  op, modrm;
   logic [1:0]  mode, sw;
   logic [2:0]  rm;
   logic [7:0]  ib [6];
   logic [15:0] base_word, base_pointer, source_index, destination_index;
   logic [7:0]  count_low_byte;
   logic        rep_z;
   logic        cond_raw;
   logic [2:0]  imm_at;

   assign op                = insn[7:0];
   assign modrm             = insn[15:8];
   assign mode              = modrm[7:6];
   assign rm                = modrm[2:0];
   assign sw                = op[1:0];
   assign base_word         = base[15:0];
   assign base_pointer      = base[31:16];
   assign source_index      = index[15:0];
   assign destination_index = index[31:16];
   assign count_low_byte    = ctrl[7:0];
   assign rep_z             = ctrl[8];

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lo
         assign ib[g] = insn[g*8 +: 8];
      end
      for (g = 0; g < 2; g++) begin : g_hi
         assign ib[g+4] = tail[g*8 +: 8];
      end
   endgenerate

   always_comb begin
      next_dec = '0;
      next_dec.word_op  = op[0];
      next_dec.to_reg   = op[1];
      next_dec.valid    = !(op == OPC_MOV_SEG &&
                            ofd_seg_e'(modrm[4:3]) == code_segment);
      next_dec.reg_sel  = modrm[5:3];
      next_dec.reg_high = !op[0] && modrm[5];
      next_dec.seg      = ofd_seg_e'(modrm[4:3]);
      next_dec.rm_sel   = rm;
      next_dec.reg_mode = (mode == MOD_REG);
      next_dec.rm_high  = next_dec.reg_mode && !op[0] && rm[2];
      next_dec.direct_addr = (mode == MOD_NODISP)
                             && (rm == RM_DIRECT);
      unique case (mode)
         MOD_NODISP: begin
            if (next_dec.direct_addr) begin
               next_dec.disp_len = 2'h2;
               next_dec.disp     = {ib[3], ib[2]};
            end else begin
               next_dec.disp_len = 2'h0;
               next_dec.disp     = 16'h0000;
            end
         end
         MOD_DISP8: begin
            next_dec.disp_len = 2'h1;
            next_dec.disp     = {{8{ib[2][7]}}, ib[2]};
         end
         MOD_DISP16: begin
            next_dec.disp_len = 2'h2;
            next_dec.disp     = {ib[3], ib[2]};
         end
         MOD_REG: begin
            next_dec.disp_len = 2'h0;
            next_dec.disp     = 16'h0000;
         end
      endcase
      // sums drop the carry out of bit 15
      if (next_dec.reg_mode) begin
         next_dec.location = 16'h0000;
      end else if (next_dec.direct_addr) begin
         next_dec.location = next_dec.disp;
      end else begin
         unique case (rm)
            3'h0: next_dec.location = 16'(base_word + source_index
                                      + next_dec.disp);
            3'h1: next_dec.location = 16'(base_word + destination_index
                                      + next_dec.disp);
            3'h2: next_dec.location = 16'(base_pointer + source_index
                                      + next_dec.disp);
            3'h3: next_dec.location = 16'(base_pointer + destination_index
                                      + next_dec.disp);
            3'h4: next_dec.location = 16'(source_index
                                      + next_dec.disp);
            3'h5: next_dec.location = 16'(destination_index
                                      + next_dec.disp);
            3'h6: next_dec.location = 16'(base_pointer + next_dec.disp);
            3'h7: next_dec.location = 16'(base_word + next_dec.disp);
         endcase
      end
      // immediate follows the displacement bytes
      imm_at = 3'(3'h2 + {1'b0, next_dec.disp_len});
      if (sw == SW_WORD) begin
         next_dec.imm_len = 2'h2;
         next_dec.imm     = {ib[imm_at + 3'h1], ib[imm_at]};
      end else if (sw == SW_SEXT) begin
         next_dec.imm_len = 2'h1;
         next_dec.imm     = {{8{ib[imm_at][7]}}, ib[imm_at]};
      end else begin
         next_dec.imm_len = 2'h1;
         next_dec.imm     = {8'h00, ib[imm_at]};
      end
      next_dec.shift_count = op[1] ? count_low_byte : SHIFT_ONE;
      next_dec.rep_continue = (rep_z == status[FL_ZERO]);
      // unsigned groups use carry, signed use sign versus overflow
      unique case (op[3:1])
         CB_OVF:  cond_raw = status[FL_OVF];
         CB_BLW:  cond_raw = status[FL_CARRY];
         CB_EQ:   cond_raw = status[FL_ZERO];
         CB_BE:   cond_raw = status[FL_CARRY] | status[FL_ZERO];
         CB_SGN:  cond_raw = status[FL_SIGN];
         CB_PAR:  cond_raw = status[FL_PARITY];
         CB_LESS: cond_raw = status[FL_SIGN] ^ status[FL_OVF];
         CB_LE:   cond_raw = (status[FL_SIGN] ^ status[FL_OVF])
                             | status[FL_ZERO];
      endcase
      next_dec.cond_true = cond_raw ^ op[0];
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dec <= '0;
      end else begin
         dec <= next_dec;
      end
   end

   // checks
   sequence s_insn_write;
      do_write && aw_addr == OFS_INSN;
   endsequence

   chk_size_bit: assert property (@(posedge sys_clk)
      disable iff (rst) s_insn_write ##2 1'b1 |-> dec.word_op == insn[0])
      else $error("size bit not reflected");
   chk_dir_bit: assert property (@(posedge sys_clk)
      disable iff (rst) s_insn_write ##2 1'b1 |-> dec.to_reg == insn[1])
      else $error("direction bit not reflected");
   chk_word_imm: assert property (@(posedge sys_clk)
      disable iff (rst) $past(sw) == SW_WORD |-> dec.imm_len == 2'h2)
      else $error("word immediate length wrong");
   chk_sext_imm: assert property (@(posedge sys_clk)
      disable iff (rst)
      $past(sw) == SW_SEXT |-> dec.imm[15:8] == {8{dec.imm[7]}})
      else $error("immediate not sign extended");
   // decode is still all zero at the first edge after reset
   chk_shift_one: assert property (@(posedge sys_clk)
      disable iff (rst)
      !$past(rst) && !$past(op[1]) |-> dec.shift_count == SHIFT_ONE)
      else $error("shift count not one");
   chk_rep_zero: assert property (@(posedge sys_clk)
      disable iff (rst) !$past(rst) |->
         dec.rep_continue == ($past(rep_z) == $past(status[FL_ZERO])))
      else $error("repeat decision wrong");
   chk_reg_form: assert property (@(posedge sys_clk)
      disable iff (rst)
      $past(mode) == MOD_REG |-> dec.reg_mode && dec.disp_len == 2'h0)
      else $error("register form misdecoded");
   chk_disp_byte: assert property (@(posedge sys_clk)
      disable iff (rst) $past(mode) == MOD_DISP8 |->
         dec.disp_len == 2'h1 && dec.disp[15:8] == {8{dec.disp[7]}})
      else $error("byte displacement wrong");
   chk_disp_word: assert property (@(posedge sys_clk)
      disable iff (rst)
      $past(mode) == MOD_DISP16 |-> dec.disp == $past(insn[31:16]))
      else $error("word displacement wrong");
   chk_direct_addr: assert property (@(posedge sys_clk)
      disable iff (rst) $past(mode) == MOD_NODISP && $past(rm) == RM_DIRECT
      |-> dec.location == $past(insn[31:16]))
      else $error("direct address wrong");
   chk_no_code_mov: assert property (@(posedge sys_clk)
      disable iff (rst) $past(op) == OPC_MOV_SEG && $past(modrm[4:3]) == 2'h1
      |-> !dec.valid)
      else $error("code segment move accepted");
   chk_status_undef: assert property (@(posedge sys_clk)
      disable iff (rst) (status & ~STATUS_MASK) == 16'h0000)
      else $error("undefined status bit set");
endmodule
`default_nettype wire

/* File: design/ofd_pkg.sv */
// Function
// - s:w 01 takes two immediate bytes
// - s:w 11 sign-extends one immediate byte
// - count origin: 0 gives one, 1 count_low_byte
// - repeat bit compared against zero_flag
// - direction bit 1 to register, 0 from
// - size bit 1 word, 0 byte
// - form 11 makes locator a register index
// - form 00 has no displacement bytes unless locator is 110
// - form 01 sign-extends one displacement byte
// - form 10 takes two bytes, low first
// - locators 000-011 sum two registers plus displacement
// - locators 100-111 one register plus displacement
// - form 00 locator 110 is direct address
// - displacement precedes immediate after second byte
// - register and segment index mapping
// - status word bit layout, upper four undefined
// - move into code segment is invalid
// - above/below unsigned, greater/less signed
package ofd_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_INSN   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_TAIL   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_BASE   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_INDEX  = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_DECODE = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_ADDR   = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_IMM    = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_SEL    = 8'h2c;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // addressing forms
   localparam logic [1:0] MOD_NODISP = 2'h0;
   localparam logic [1:0] MOD_DISP8  = 2'h1;
   localparam logic [1:0] MOD_DISP16 = 2'h2;
   localparam logic [1:0] MOD_REG    = 2'h3;
   localparam logic [2:0] RM_DIRECT  = 3'h6;
   localparam logic [1:0] SW_WORD    = 2'h1;
   localparam logic [1:0] SW_SEXT    = 2'h3;
   localparam logic [7:0] OPC_MOV_SEG = 8'h8e;
   localparam logic [7:0] SHIFT_ONE   = 8'h01;
   // status word bit positions
   localparam int FL_CARRY  = 0;
   localparam int FL_PARITY = 2;
   localparam int FL_HALF   = 4;
   localparam int FL_ZERO   = 6;
   localparam int FL_SIGN   = 7;
   localparam int FL_TRAP   = 8;
   localparam int FL_IF     = 9;
   localparam int FL_DIR    = 10;
   localparam int FL_OVF    = 11;
   localparam logic [15:0] STATUS_MASK = 16'h0fd5;
   // condition groups, low bit of the code inverts
   localparam logic [2:0] CB_OVF  = 3'h0;
   localparam logic [2:0] CB_BLW  = 3'h1;
   localparam logic [2:0] CB_EQ   = 3'h2;
   localparam logic [2:0] CB_BE   = 3'h3;
   localparam logic [2:0] CB_SGN  = 3'h4;
   localparam logic [2:0] CB_PAR  = 3'h5;
   localparam logic [2:0] CB_LESS = 3'h6;
   localparam logic [2:0] CB_LE   = 3'h7;
   typedef enum logic [1:0] {
      extra_segment, code_segment, stack_segment, data_segment
   } ofd_seg_e;
   typedef struct packed {
      logic        valid;
      logic        word_op;
      logic        to_reg;
      logic        reg_mode;
      logic        direct_addr;
      logic [1:0]  disp_len;
      logic [1:0]  imm_len;
      logic [2:0]  reg_sel;
      logic        reg_high;
      logic [2:0]  rm_sel;
      logic        rm_high;
      ofd_seg_e    seg;
      logic        rep_continue;
      logic        cond_true;
      logic [7:0]  shift_count;
      logic [15:0] location;
      logic [15:0] disp;
      logic [15:0] imm;
   } ofd_dec_s;
endpackage

/* File: dv/ofd_exec_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ofd_exec_model
   import ofd_pkg::*;
(
   // clock and reset
   input  wire logic     sys_clk,
   input  wire logic     rst,
   // decode in, operand taken by execution
   input  wire ofd_dec_s dec,
   output ofd_dec_s      taken
);
   // execution stage latches the decode it acts on
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         taken <= '0;
      end else begin
         taken <= dec;
      end
   end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb
   import ofd_pkg::*;
();
   logic        sys_clk, rst;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   ofd_dec_s    dec, seen;
   int          err_total, checks, cyc;
   logic [15:0] loc_exp [8] = '{16'h1400, 16'h1140, 16'h2400, 16'h2140,
                                16'h0400, 16'h0140, 16'h2100, 16'h1100};
   // expected decode word, status word, opcode
   logic [39:0] cond_tab [6] = '{{16'h3c8d, 16'h0001, 8'h72},
      {16'h0889, 16'h0001, 8'h7c}, {16'h0c89, 16'h0080, 8'h7c},
      {16'h388d, 16'h0080, 8'h72}, {16'h0889, 16'h0880, 8'h7c},
      {16'h388d, 16'h0080, 8'h76}};

   ofd_decoder i_dut (.sys_clk(sys_clk), .rst(rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .dec(dec));
   ofd_exec_model i_exec (.sys_clk(sys_clk), .rst(rst), .dec(dec),
      .taken(seen));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic wrap_up();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen_v,
                      input logic [31:0] exp_v);
      checks++;
      if (seen_v !== exp_v) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp_v, seen_v);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge sys_clk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
      chk($sformatf("bresp_%h", a), {30'h0, s_axi_bresp}, {30'h0, er});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
      rd_d = s_axi_rdata;
      chk($sformatf("rresp_%h", a), {30'h0, s_axi_rresp}, {30'h0, er});
      chk($sformatf("rdata_%h", a), rd_d, e);
   endtask

   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      err_total = 0;
      checks = 0;
      cyc = 0;
      rst = 1'b1;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd_chk(OFS_DECODE, 32'h0000_0a81, RESP_OKAY);
      axi_wr(OFS_BASE, 32'h2000_1000, RESP_OKAY);
      axi_wr(OFS_INDEX, 32'h0040_0300, RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         axi_wr(OFS_INSN, {16'h0100, 5'b10000, i[2:0], 8'h81}, RESP_OKAY);
         rd_chk(OFS_ADDR, {16'h0100, loc_exp[i]}, RESP_OKAY);
         chk("taken_location", {16'h0, seen.location},
             {16'h0, loc_exp[i]});
      end
      // no displacement bytes, immediate right after the second byte
      axi_wr(OFS_INSN, 32'h1234_0281, RESP_OKAY);
      rd_chk(OFS_ADDR, 32'h0000_2300, RESP_OKAY);
      rd_chk(OFS_IMM, 32'h0000_1234, RESP_OKAY);
      // word immediate, two displacement bytes
      axi_wr(OFS_INSN, 32'h1234_9081, RESP_OKAY);
      axi_wr(OFS_TAIL, 32'h0000_abcd, RESP_OKAY);
      rd_chk(OFS_DECODE, 32'h0000_0f43, RESP_OKAY);
      rd_chk(OFS_ADDR, 32'h1234_2534, RESP_OKAY);
      rd_chk(OFS_IMM, 32'h0000_abcd, RESP_OKAY);
      rd_chk(OFS_SEL, 32'h0000_0202, RESP_OKAY);
      // short displacement, sign-extended immediate, address wrap
      axi_wr(OFS_BASE, 32'h2000_0020, RESP_OKAY);
      axi_wr(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
      axi_wr(OFS_INSN, 32'h80f0_4783, RESP_OKAY);
      rd_chk(OFS_DECODE, 32'h0000_02a7, RESP_OKAY);
      rd_chk(OFS_ADDR, 32'hfff0_0010, RESP_OKAY);
      rd_chk(OFS_IMM, 32'h0000_ff80, RESP_OKAY);
      rd_chk(OFS_SEL, 32'h0000_0070, RESP_OKAY);
      // direct address, count from count_low_byte
      axi_wr(OFS_STATUS, 32'h0000_0040, RESP_OKAY);
      axi_wr(OFS_CTRL, 32'h0000_0107, RESP_OKAY);
      axi_wr(OFS_INSN, 32'h5678_0e8b, RESP_OKAY);
      axi_wr(OFS_TAIL, 32'h0000_0005, RESP_OKAY);
      rd_chk(OFS_DECODE, 32'h0000_3ed7, RESP_OKAY);
      rd_chk(OFS_ADDR, 32'h5678_5678, RESP_OKAY);
      rd_chk(OFS_IMM, 32'h0000_0005, RESP_OKAY);
      rd_chk(OFS_SEL, 32'h0000_0161, RESP_OKAY);
      // register form byte operation, repeat stops on zero_flag clear
      axi_wr(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
      axi_wr(OFS_INSN, 32'h0099_e502, RESP_OKAY);
      rd_chk(OFS_DECODE, 32'h0000_388d, RESP_OKAY);
      rd_chk(OFS_ADDR, 32'h0000_0000, RESP_OKAY);
      rd_chk(OFS_IMM, 32'h0000_0099, RESP_OKAY);
      rd_chk(OFS_SEL, 32'h0000_00dc, RESP_OKAY);
      // move into code segment refused, into data segment kept
      axi_wr(OFS_INSN, 32'h0000_c88e, RESP_OKAY);
      rd_chk(OFS_DECODE, 32'h0000_388c, RESP_OKAY);
      axi_wr(OFS_INSN, 32'h0000_d88e, RESP_OKAY);
      rd_chk(OFS_DECODE, 32'h0000_388d, RESP_OKAY);
      rd_chk(OFS_SEL, 32'h0000_0303, RESP_OKAY);
      for (int i = 0; i < 6; i++) begin
         axi_wr(OFS_STATUS, {16'h0, cond_tab[i][23:8]}, RESP_OKAY);
         axi_wr(OFS_INSN, {16'h0, 8'hc0, cond_tab[i][7:0]}, RESP_OKAY);
         rd_chk(OFS_DECODE, {16'h0, cond_tab[i][39:24]},
                RESP_OKAY);
      end
      axi_wr(OFS_STATUS, 32'hffff_ffff, RESP_OKAY);
      rd_chk(OFS_STATUS, 32'h0000_0fd5, RESP_OKAY);
      axi_wr(8'h40, 32'h1234_5678, RESP_SLVERR);
      rd_chk(8'h40, 32'h0000_0000, RESP_SLVERR);
      // read-only decode ignores writes
      rd_chk(OFS_DECODE, 32'h0000_3e8d, RESP_OKAY);
      axi_wr(OFS_DECODE, 32'hffff_ffff, RESP_OKAY);
      rd_chk(OFS_DECODE, 32'h0000_3e8d, RESP_OKAY);
      wrap_up();
   end
endmodule
`default_nettype wire
